// *** design/qfsb_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// controller end: software drives the link through wishbone registers
module qfsb_ctrl
    import qfsb_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // static mode strap
    input  wire logic        mode_polled,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    // link
    qfsb_link_if.ctrl        lnk
);
    logic [7:0]  waddr_ff, raddr_ff;     // queue addresses
    logic        wsel_ff, almost_full_bus_strobe_ff, almost_empty_bus_strobe_ff; // one-cycle strobes
    logic [2:0]  sync_m1_ff, sync_m2_ff; // pin synchronisers
    logic        full_prev_ff;
    logic [QFSB_EV_W-1:0] stat_ff, en_ff;
    logic [QFSB_EV_W-1:0] ev;
    logic        req, wr;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // write lands at the edge where the master sees ack
    assign wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    assign lnk.flag_bus_mode_select    = mode_polled;
    assign lnk.write_queue_address     = waddr_ff;
    assign lnk.write_address_enable    = wsel_ff;
    assign lnk.read_queue_address      = raddr_ff;
    assign lnk.almost_full_bus_strobe  = almost_full_bus_strobe_ff && !mode_polled && !lnk.serial_enable_out;
    assign lnk.almost_empty_bus_strobe = almost_empty_bus_strobe_ff && !mode_polled && !lnk.serial_enable_out;

    // command writes, strobes last one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            waddr_ff <= 8'h00;
            raddr_ff <= 8'h00;
            wsel_ff  <= 1'b0;
            almost_full_bus_strobe_ff  <= 1'b0;
            almost_empty_bus_strobe_ff  <= 1'b0;
        end else begin
            wsel_ff <= 1'b0;
            almost_full_bus_strobe_ff <= 1'b0;
            almost_empty_bus_strobe_ff <= 1'b0;
            if (wr && wb_adr_i == QFSB_REG_CTRL) begin
                waddr_ff <= wb_dat_i[QFSB_CTRL_WADDR_LSB +: 8];
                raddr_ff <= wb_dat_i[QFSB_CTRL_RADDR_LSB +: 8];
                wsel_ff  <= wb_dat_i[QFSB_CTRL_WSEL_BIT];
                almost_full_bus_strobe_ff  <= wb_dat_i[QFSB_CTRL_STROBE];
                almost_empty_bus_strobe_ff  <= wb_dat_i[QFSB_CTRL_RSTR_BIT];
            end
        end
    end

    // two-flop synchronisers for full, sync lines
    always_ff @(posedge clk) begin
        if (rst) begin
            // idle levels: sync lines low, full line high, so no false event
            sync_m1_ff <= 3'h1;
            sync_m2_ff <= 3'h1;
            full_prev_ff <= 1'b1;
        end else begin
            sync_m1_ff <= {lnk.almost_empty_bus_sync, lnk.almost_full_bus_sync, lnk.full_flag};
            sync_m2_ff <= sync_m1_ff;
            full_prev_ff <= sync_m2_ff[0];
        end
    end

    // events: full went low, either sync pulse seen
    // full fall tells software to hold writes
    assign ev = {sync_m2_ff[2], sync_m2_ff[1], full_prev_ff && !sync_m2_ff[0]};

    // sticky status, set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_ff <= '0;
            en_ff   <= '0;
        end else begin
            if (wr && wb_adr_i == QFSB_REG_IRQ_EN) begin
                en_ff <= wb_dat_i[QFSB_EV_W-1:0];
            end
            if (wr && wb_adr_i == QFSB_REG_IRQ_CL) begin
                stat_ff <= (stat_ff & ~wb_dat_i[QFSB_EV_W-1:0]) | ev;
            end else begin
                stat_ff <= stat_ff | ev;
            end
        end
    end

    // bus answer, one registered ack per request, one wait state
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            irq      <= 1'b0;
        end else begin
            wb_ack_o <= req;
            irq      <= |(stat_ff & en_ff);
            case (wb_adr_i)
                QFSB_REG_CTRL:   wb_dat_o <= {7'h0, almost_empty_bus_strobe_ff, raddr_ff, 6'h0, almost_full_bus_strobe_ff, wsel_ff, waddr_ff};
                QFSB_REG_STATUS: wb_dat_o <= {29'h0, stat_ff};
                QFSB_REG_IRQ_EN: wb_dat_o <= {29'h0, en_ff};
                default:         wb_dat_o <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** pkg/qfsb_pkg.sv ***
package qfsb_pkg;
    // queue addressing: 3 device-id bits above 5 queue bits
    localparam int QFSB_ADDR_W     = 8;
    localparam int QFSB_QUEUE_W    = 5;
    localparam int QFSB_ID_W       = 3;
    localparam int QFSB_QUEUES     = 16;
    localparam int QFSB_BUS_W      = 8;
    localparam int QFSB_SECTORS    = 2;
    localparam int QFSB_MAX_DEVS   = 8;
    // sector index: queues 0..7 are sector 1, 8..15 sector 2
    localparam int QFSB_SECT_BIT   = 3;
    // values after reset
    localparam logic QFSB_RST_SYNC     = 1'b0;
    localparam logic QFSB_RST_TOKEN    = 1'b0;
    localparam logic QFSB_RST_SECTOR   = 1'b0;
    localparam logic [7:0] QFSB_RST_BUS = 8'hFF;
    localparam logic QFSB_MODE_DIRECT  = 1'b0;
    localparam logic QFSB_MODE_POLLED  = 1'b1;
    // controller register map (byte offsets)
    localparam logic [3:0] QFSB_REG_CTRL   = 4'h0;
    localparam logic [3:0] QFSB_REG_STATUS = 4'h4;
    localparam logic [3:0] QFSB_REG_IRQ_EN = 4'h8;
    localparam logic [3:0] QFSB_REG_IRQ_CL = 4'hC;
    // control register fields
    localparam int QFSB_CTRL_WADDR_LSB = 0;
    localparam int QFSB_CTRL_WSEL_BIT  = 8;
    localparam int QFSB_CTRL_STROBE    = 9;
    localparam int QFSB_CTRL_RADDR_LSB = 16;
    localparam int QFSB_CTRL_RSTR_BIT  = 24;
    // event bits
    localparam int QFSB_EV_FULL  = 0;
    localparam int QFSB_EV_WSYNC = 1;
    localparam int QFSB_EV_RSYNC = 2;
    localparam int QFSB_EV_W     = 3;
endpackage

// *** pkg/qfsb_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface qfsb_link_if;
    import qfsb_pkg::*;
    // write port queue selection
    logic [QFSB_ADDR_W-1:0] write_queue_address;
    logic                   write_address_enable;
    // shared full flag line, three signals
    logic                   full_flag_o;
    logic                   full_flag_oe;
    logic                   full_flag;
    // almost-full bus side
    logic                   almost_full_bus_strobe;
    logic [QFSB_BUS_W-1:0]  almost_full_flag_bus;
    logic                   almost_full_bus_sync;
    logic                   almost_full_token_in;
    logic                   almost_full_token_out;
    // almost-empty bus side
    logic [QFSB_ADDR_W-1:0] read_queue_address;
    logic                   almost_empty_bus_strobe;
    logic [QFSB_BUS_W-1:0]  almost_empty_flag_bus;
    logic                   almost_empty_bus_sync;
    logic                   almost_empty_token_in;
    logic                   almost_empty_token_out;
    // static setup
    logic                   flag_bus_mode_select;
    logic                   serial_enable_out;
    // resolved line: pulled high (not full) when nobody drives
    assign full_flag = full_flag_oe ? full_flag_o : 1'b1;
    modport device (
        input  write_queue_address, write_address_enable, almost_full_bus_strobe,
        input  almost_full_token_in, read_queue_address, almost_empty_bus_strobe,
        input  almost_empty_token_in, flag_bus_mode_select,
        output full_flag_o, full_flag_oe, almost_full_flag_bus, almost_full_bus_sync,
        output almost_full_token_out, almost_empty_flag_bus, almost_empty_bus_sync,
        output almost_empty_token_out, serial_enable_out
    );
    modport ctrl (
        output write_queue_address, write_address_enable, almost_full_bus_strobe,
        output read_queue_address, almost_empty_bus_strobe, flag_bus_mode_select,
        input  full_flag, almost_full_flag_bus, almost_full_bus_sync,
        input  almost_full_token_out, almost_empty_flag_bus, almost_empty_bus_sync,
        input  almost_empty_token_out, serial_enable_out
    );
endinterface
`default_nettype wire

// *** design/qfsb_flag_bus.sv ***
`timescale 1ns/1ps
`default_nettype none
// one flag bus engine; instantiated once per bus direction
module qfsb_flag_bus
    import qfsb_pkg::*;
#(
    parameter int BUS_W = QFSB_BUS_W
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // setup
    input  wire logic                   polled,
    input  wire logic                   prog_done,
    input  wire logic [QFSB_ID_W-1:0]   dev_id,
    // per-queue flags, active low
    input  wire logic [2*BUS_W-1:0]     flags_n,
    // direct selection
    input  wire logic                   strobe,
    input  wire logic [QFSB_ADDR_W-1:0] addr,
    // token chain
    input  wire logic                   token_in,
    output logic                        token_out,
    // bus outputs
    output logic [BUS_W-1:0]            bus,
    output logic                        sync
);
    logic             sector_ff;   // 0 = sector 1, 1 = sector 2
    logic             nxt_sector;  // sector shown from this edge on
    logic             active_ff;   // sector 1 of this device is on the bus
    logic             start_ff;    // ring not yet seeded since reset
    logic             kick;        // device 0 seeds the polling ring
    logic             load1;       // polled: sector 1 goes out at this edge
    logic             load2;       // polled: sector 2 goes out at this edge
    logic             sel_hit;     // direct strobe addresses this device
    logic [BUS_W-1:0] sect_flags;  // flags of the chosen sector

    assign sel_hit    = strobe && prog_done && !polled && (addr[QFSB_ADDR_W-1 -: QFSB_ID_W] == dev_id);
    // without a seed a looped ring would never start; device 0 plays master
    assign kick       = polled && prog_done && start_ff && (dev_id == '0);
    assign load1      = polled && prog_done && (token_in || kick);
    assign load2      = polled && active_ff;
    assign sect_flags = nxt_sector ? flags_n[2*BUS_W-1:BUS_W] : flags_n[BUS_W-1:0];

    // sector choice: direct from address, polled one then two
    always_comb begin
        nxt_sector = sector_ff;
        if (sel_hit) begin
            nxt_sector = addr[QFSB_SECT_BIT];
        end else if (load1) begin
            nxt_sector = 1'b0;
        end else if (load2) begin
            nxt_sector = 1'b1;
        end
    end

    // sector register
    always_ff @(posedge clk) begin
        if (rst) begin
            sector_ff <= QFSB_RST_SECTOR;
        end else begin
            sector_ff <= nxt_sector;
        end
    end

    // seed issued once per reset
    always_ff @(posedge clk) begin
        if (rst) begin
            start_ff <= 1'b1;
        end else if (kick) begin
            start_ff <= 1'b0;
        end
    end

    // polled ownership: one cycle of sector 1, then sector 2 follows
    always_ff @(posedge clk) begin
        if (rst) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= load1;
        end
    end

    // bus, sync and token outputs registered
    always_ff @(posedge clk) begin
        if (rst) begin
            bus       <= QFSB_RST_BUS;
            sync      <= QFSB_RST_SYNC;
            token_out <= QFSB_RST_TOKEN;
        end else begin
            // bus held idle until programming done
            if (prog_done) begin
                bus <= sect_flags;
            end
            sync      <= load1;
            token_out <= load2;
        end
    end
endmodule
`default_nettype wire

// *** design/qfsb_device.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - full flag follows new queue next cycle
// - controller writes only when flag high
// - only selected device drives full line
// - drive full line the cycle after selection
// - latch flag mode at master reset
// - mode input stable from before reset
// - direct mode: strobe selects bus sector
// - polled mode: strobe tied low
// - strobe idle until programming done
// - polled: sectors alternate one, two, one
// - sync high on sector one only
// - accept token from previous device
// - single device: token tied or looped
// - direct expansion: first token input low
// - pulse token out with sector two
// - token received: load sector one next
module qfsb_device
    import qfsb_pkg::*;
#(
    parameter logic [QFSB_ID_W-1:0] DEV_ID = 3'h0
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // link to the controller
    qfsb_link_if.device                lnk,
    // user side queue status, active low
    input  wire logic [QFSB_QUEUES-1:0] queue_full_n,
    input  wire logic [QFSB_QUEUES-1:0] queue_almost_full_n,
    input  wire logic [QFSB_QUEUES-1:0] queue_almost_empty_n,
    input  wire logic                   prog_done
);
    logic                    mode_ff;     // latched flag mode
    logic [QFSB_QUEUE_W-1:0] wqueue_ff;   // active write queue
    logic                    owner_ff;    // this device owns full line
    logic                    ffo_ff;      // full flag value driven
    logic                    serial_enable_out_ff;     // serial enable out, low when done
    logic                    whit;        // write selection hits us

    assign whit = lnk.write_address_enable &&
                  (lnk.write_queue_address[QFSB_ADDR_W-1 -: QFSB_ID_W] == DEV_ID);

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ff <= lnk.flag_bus_mode_select;
        end
    end

    // programming status reflected on serial enable out
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_enable_out_ff <= 1'b1;
        end else begin
            serial_enable_out_ff <= !prog_done;
        end
    end

    // write queue selection
    always_ff @(posedge clk) begin
        if (rst) begin
            wqueue_ff <= '0;
            owner_ff  <= 1'b0;
        end else if (lnk.write_address_enable) begin
            wqueue_ff <= lnk.write_queue_address[QFSB_QUEUE_W-1:0];
            owner_ff  <= whit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ffo_ff <= 1'b1;
        end else if (whit) begin
            ffo_ff <= queue_full_n[lnk.write_queue_address[QFSB_QUEUE_W-2:0]];
        end else begin
            ffo_ff <= queue_full_n[wqueue_ff[QFSB_QUEUE_W-2:0]];
        end
    end

    assign lnk.full_flag_o       = ffo_ff;
    assign lnk.full_flag_oe      = owner_ff;
    assign lnk.serial_enable_out = serial_enable_out_ff;

    // almost-full bus on write side
    qfsb_flag_bus #(.BUS_W(QFSB_BUS_W)) u_af (
        .clk      (clk),
        .rst      (rst),
        .polled   (mode_ff),
        .prog_done(!serial_enable_out_ff),
        .dev_id   (DEV_ID),
        .flags_n  (queue_almost_full_n),
        .strobe   (lnk.almost_full_bus_strobe),
        .addr     (lnk.write_queue_address),
        .token_in (lnk.almost_full_token_in),
        .token_out(lnk.almost_full_token_out),
        .bus      (lnk.almost_full_flag_bus),
        .sync     (lnk.almost_full_bus_sync)
    );

    qfsb_flag_bus #(.BUS_W(QFSB_BUS_W)) u_ae (
        .clk      (clk),
        .rst      (rst),
        .polled   (mode_ff),
        .prog_done(!serial_enable_out_ff),
        .dev_id   (DEV_ID),
        .flags_n  (queue_almost_empty_n),
        .strobe   (lnk.almost_empty_bus_strobe),
        .addr     (lnk.read_queue_address),
        .token_in (lnk.almost_empty_token_in),
        .token_out(lnk.almost_empty_token_out),
        .bus      (lnk.almost_empty_flag_bus),
        .sync     (lnk.almost_empty_bus_sync)
    );
endmodule
`default_nettype wire

// *** testbench/qfsb_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the link between controller and device
module qfsb_chk
    import qfsb_pkg::*;
#(
    parameter logic [QFSB_ID_W-1:0] DEV_ID = 3'h0
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // write queue selection and full line
    input wire logic [QFSB_ADDR_W-1:0] write_queue_address,
    input wire logic                   write_address_enable,
    input wire logic                   full_flag_oe,
    // strobes and setup
    input wire logic                   almost_full_bus_strobe,
    input wire logic                   almost_empty_bus_strobe,
    input wire logic                   flag_bus_mode_select,
    input wire logic                   serial_enable_out,
    // polled chain
    input wire logic                   almost_full_bus_sync,
    input wire logic                   almost_full_token_in,
    input wire logic                   almost_full_token_out,
    input wire logic                   almost_empty_bus_sync,
    input wire logic                   almost_empty_token_in,
    input wire logic                   almost_empty_token_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // selection aimed at this device or at another one
    wire sel_me = write_address_enable && write_queue_address[7:5] == DEV_ID;
    wire sel_other = write_address_enable && write_queue_address[7:5] != DEV_ID;
    // mode strap, steady outside reset
    wire pol = flag_bus_mode_select;

    property p_oe_on; sel_me |=> full_flag_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("full line not driven");
    property p_oe_off; sel_other |=> !full_flag_oe [*2]; endproperty
    a_oe_off: assert property (p_oe_off) else $error("full line driven when not selected");
    property p_almost_full_bus_strobe_ok; almost_full_bus_strobe |-> !pol && !serial_enable_out; endproperty
    a_almost_full_bus_strobe_ok: assert property (p_almost_full_bus_strobe_ok) else $error("af strobe when not allowed");
    property p_almost_empty_bus_strobe_ok; almost_empty_bus_strobe |-> !pol && !serial_enable_out; endproperty
    a_almost_empty_bus_strobe_ok: assert property (p_almost_empty_bus_strobe_ok) else $error("ae strobe when not allowed");
    property p_af_seq; pol && almost_full_bus_sync |=> $fell(almost_full_bus_sync) && almost_full_token_out; endproperty
    a_af_seq: assert property (p_af_seq) else $error("af sector two missing");
    property p_ae_seq; pol && almost_empty_bus_sync |=> !almost_empty_bus_sync && almost_empty_token_out; endproperty
    a_ae_seq: assert property (p_ae_seq) else $error("ae sector two missing");
    property p_af_tok; pol && almost_full_token_in |=> almost_full_bus_sync; endproperty
    a_af_tok: assert property (p_af_tok) else $error("af token not followed by sector one");
    property p_ae_tok; pol && almost_empty_token_in |=> almost_empty_bus_sync; endproperty
    a_ae_tok: assert property (p_ae_tok) else $error("ae token not followed by sector one");
    property p_direct; !pol |-> !almost_full_bus_sync && !almost_full_token_out; endproperty
    a_direct: assert property (p_direct) else $error("polling activity in direct mode");
    property p_tok_pulse; $rose(almost_full_token_out) |=> $fell(almost_full_token_out); endproperty
    a_tok_pulse: assert property (p_tok_pulse) else $error("token out not a pulse");
endmodule
`default_nettype wire

// *** testbench/qfsb_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// one device looped to its controller, software side on wishbone
module qfsb_tb;
    import qfsb_pkg::*;
    // clock, reset and straps
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic        mode_polled = 1'b0;
    logic        prog_done   = 1'b0;
    // wishbone master side
    logic        wb_cyc  = 1'b0;
    logic        wb_stb  = 1'b0;
    logic        wb_we   = 1'b0;
    logic [3:0]  wb_adr  = 4'h0;
    logic [3:0]  wb_sel  = 4'hF;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        irq;
    logic [31:0] rd;
    // queue status, active low
    logic [15:0] full_n = 16'hA5C3;
    logic [15:0] af_n   = 16'h3C5A;
    logic [15:0] ae_n   = 16'h96E1;
    // counters
    int          n_fail     = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    qfsb_link_if lnk ();
    // token looped back when polled, held low when direct
    assign lnk.almost_full_token_in  = mode_polled & lnk.almost_full_token_out;
    assign lnk.almost_empty_token_in = mode_polled & lnk.almost_empty_token_out;
    qfsb_device #(.DEV_ID(3'h0)) qfsb_device_inst (.clk(clk), .rst(rst), .lnk(lnk), .queue_full_n(full_n),
        .queue_almost_full_n(af_n), .queue_almost_empty_n(ae_n), .prog_done(prog_done));
    qfsb_ctrl qfsb_ctrl_inst (.clk(clk), .rst(rst), .mode_polled(mode_polled), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq(irq), .lnk(lnk));
    qfsb_chk #(.DEV_ID(3'h0)) qfsb_chk_inst (.clk(clk), .rst(rst),
        .write_queue_address(lnk.write_queue_address), .write_address_enable(lnk.write_address_enable),
        .full_flag_oe(lnk.full_flag_oe), .almost_full_bus_strobe(lnk.almost_full_bus_strobe),
        .almost_empty_bus_strobe(lnk.almost_empty_bus_strobe), .flag_bus_mode_select(lnk.flag_bus_mode_select),
        .serial_enable_out(lnk.serial_enable_out), .almost_full_bus_sync(lnk.almost_full_bus_sync),
        .almost_full_token_in(lnk.almost_full_token_in), .almost_full_token_out(lnk.almost_full_token_out),
        .almost_empty_bus_sync(lnk.almost_empty_bus_sync), .almost_empty_token_in(lnk.almost_empty_token_in),
        .almost_empty_token_out(lnk.almost_empty_token_out));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // watchdog: a hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t watchdog expired", $time);
            stop_test();
        end
    end
    // verdict and end of run
    task automatic stop_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // compare words
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // compare single bits
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_word({31'h0, got}, {31'h0, exp}, msg);
    endtask
    // classic wishbone cycle; waits for ack however long it takes
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        @(posedge clk);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= d;
        @(posedge clk);
        while (wb_ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // select a write queue by full address
    task automatic sel_q(input logic [7:0] a);
        wb(1'b1, QFSB_REG_CTRL, {23'h0, 1'b1, a});
    endtask
    // let a few edges land, then look between edges
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // reset for 8 cycles; mode strap only moves inside reset
    task automatic do_reset(input logic pol);
        @(posedge clk);
        rst         <= 1'b1;
        mode_polled <= pol;
        prog_done   <= 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask
    // idle state after reset
    task automatic t_reset();
        settle(0);
        chk_bit(lnk.full_flag_oe, 1'b0, "oe after reset");
        chk_bit(lnk.full_flag, 1'b1, "full line idle");
        chk_word({24'h0, lnk.almost_full_flag_bus}, {24'h0, QFSB_RST_BUS}, "af bus reset");
        chk_bit(lnk.serial_enable_out, 1'b1, "serial_enable_out reset");
        chk_bit(irq, 1'b0, "irq reset");
        wb(1'b0, QFSB_REG_STATUS, 32'h0);
        chk_word(rd, 32'h0, "status reset");
    endtask
    // strobes before programming ends are ignored, then programming ends
    task automatic t_early();
        wb(1'b1, QFSB_REG_CTRL, 32'h0108_0208);
        settle(2);
        chk_word({24'h0, lnk.almost_full_flag_bus}, 32'hFF, "af bus moved early");
        chk_word({24'h0, lnk.almost_empty_flag_bus}, 32'hFF, "ae bus moved early");
        @(posedge clk);
        prog_done <= 1'b1;
        while (lnk.serial_enable_out !== 1'b0) begin
            @(posedge clk);
        end
        settle(1);
        chk_word({24'h0, lnk.almost_full_flag_bus}, {24'h0, af_n[7:0]}, "af early strobe leaked");
        chk_word({24'h0, lnk.almost_empty_flag_bus}, {24'h0, ae_n[7:0]}, "ae early strobe leaked");
    endtask
    // every queue of this device, then a queue of device 1
    task automatic t_full();
        for (int q = 0; q < 17; q++) begin
            sel_q(q < 16 ? 8'(q) : 8'h20);
            settle(1);
            chk_bit(lnk.full_flag_oe, q < 16, "full line enable");
            chk_bit(lnk.full_flag, q < 16 ? full_n[q] : 1'b1, "full flag value");
        end
    endtask
    // direct mode: both sectors on both buses
    task automatic t_direct();
        for (int s = 0; s < 2; s++) begin
            wb(1'b1, QFSB_REG_CTRL, {7'h0, 1'b1, 4'h0, s[0], 3'h0, 6'h0, 2'h2, 4'h0, s[0], 3'h0});
            settle(2);
            chk_word({24'h0, lnk.almost_full_flag_bus}, {24'h0, af_n[8*s +: 8]}, "af sector");
            chk_word({24'h0, lnk.almost_empty_flag_bus}, {24'h0, ae_n[8*s +: 8]}, "ae sector");
        end
    endtask
    // full event: raise, mask, clear; read-only and unmapped places
    task automatic t_irq();
        sel_q(8'h00);
        wb(1'b1, QFSB_REG_IRQ_CL, 32'h7);
        wb(1'b1, QFSB_REG_IRQ_EN, 32'h1);
        sel_q(8'h02);
        settle(5);
        chk_bit(irq, 1'b1, "irq on full");
        wb(1'b0, QFSB_REG_STATUS, 32'h0);
        chk_word(rd, 32'h1 << QFSB_EV_FULL, "status full");
        wb(1'b1, QFSB_REG_IRQ_EN, 32'h0);
        settle(2);
        chk_bit(irq, 1'b0, "irq masked");
        wb(1'b1, QFSB_REG_IRQ_CL, 32'h1);
        wb(1'b1, QFSB_REG_STATUS, 32'hFFFF_FFFF);
        wb(1'b0, QFSB_REG_STATUS, 32'h0);
        chk_word(rd, 32'h0, "status cleared");
        wb(1'b0, 4'h2, 32'h0);
        chk_word(rd, 32'h0, "unmapped read");
    endtask
    // polled: sector one with sync, sector two with token, sector one again
    task automatic poll_chk(input logic ae);
        logic [15:0] f;
        f = ae ? ae_n : af_n;
        settle(0);
        while ((ae ? lnk.almost_empty_bus_sync : lnk.almost_full_bus_sync) !== 1'b1) begin
            @(negedge clk);
        end
        for (int i = 0; i < 3; i++) begin
            chk_bit(ae ? lnk.almost_empty_bus_sync : lnk.almost_full_bus_sync, i != 1, "sync");
            chk_bit(ae ? lnk.almost_empty_token_out : lnk.almost_full_token_out, i == 1, "token");
            chk_word({24'h0, ae ? lnk.almost_empty_flag_bus : lnk.almost_full_flag_bus},
                {24'h0, f[8*(i%2) +: 8]}, "polled sector");
            @(negedge clk);
        end
    endtask
    // second reset into polled mode, sync event interrupt
    task automatic t_polled();
        af_n <= 16'h5AA5;
        ae_n <= 16'hC33C;
        do_reset(1'b1);
        prog_done <= 1'b1;
        poll_chk(1'b0);
        poll_chk(1'b1);
        wb(1'b1, QFSB_REG_IRQ_CL, 32'h7);
        wb(1'b1, QFSB_REG_IRQ_EN, 32'h1 << QFSB_EV_WSYNC);
        settle(4);
        chk_bit(irq, 1'b1, "irq on sync");
    endtask
    // main sequence
    initial begin
        do_reset(1'b0);
        t_reset();
        t_early();
        t_full();
        t_direct();
        t_irq();
        t_polled();
        stop_test();
    end
endmodule
`default_nettype wire
